/* rtl/tx_mode_params.svh */
// timing and encoding constants shared by the transmitter and its controller
`ifndef TX_MODE_PARAMS_SVH
`define TX_MODE_PARAMS_SVH
`define TX_MCLK_PERIOD_NS 40
`define TX_XTAL_UP_NS 600000
`define TX_LOCK_NS 200000
`define TX_CLK_WAIT_NS 600000
`define TX_SETTLE_NS 250000
`define TX_CYCLES_UP(ns) (((ns) + `TX_MCLK_PERIOD_NS - 1) / `TX_MCLK_PERIOD_NS)
`define TX_CYCLES_DN(ns) ((ns) / `TX_MCLK_PERIOD_NS)
`define TX_CNT_W 16
`define TX_CNT_ZERO 16'h0000
`define TX_CNT_ONE 16'h0001
`define TX_DIV_LAST 3'h7
`define TX_DIV_HALF 3'h4
`define TX_DIV_ZERO 3'h0
`define TX_DIV_ONE 3'h1
`define TX_LOSS_CYCLES 8'h20
`define TX_LOSS_ZERO 8'h00
`define TX_LOSS_ONE 8'h01
`endif

/* rtl/tx_mode_pkg.sv */
// types for the transmitter mode logic and the controller sequencer
package tx_mode_pkg;
  typedef enum logic [1:0] {
    MODE_POWER_DOWN,
    MODE_IDLE,
    MODE_POWER_UP
  } tx_mode_e;

  typedef enum logic [2:0] {
    CTRL_OFF,
    CTRL_ENABLING,
    CTRL_SWITCH,
    CTRL_SETTLE,
    CTRL_READY,
    CTRL_TX
  } ctrl_state_e;

  typedef struct packed {
    tx_mode_e mode;
    logic [15:0] oscCnt;
    logic [15:0] lockCnt;
    logic ampReached;
    logic clkOn;
    logic locked;
    logic paOn;
    logic synthOn;
    logic loadHighZ;
    logic freqHigh;
  } dev_state_s;

  typedef struct packed {
    ctrl_state_e state;
    logic [15:0] cnt;
    logic [7:0] lossCnt;
    logic lastRef;
    logic extSel;
    logic amplitude_key_in;
    logic freq_shift_key_in;
    logic enOut;
    logic enOe;
  } ctrl_state_s;
endpackage

/* rtl/tx_link_if.sv */
// inter-die link: two keys, a three-state enable and the reference clock
`timescale 1ns/1ns
interface tx_link_if;
  logic amplitudeKey;
  logic freqShiftKey;
  logic enableOut;
  logic enableOe;
  logic refClock;

  modport device (
    input amplitudeKey,
    input freqShiftKey,
    input enableOut,
    input enableOe,
    output refClock
  );

  modport controller (
    output amplitudeKey,
    output freqShiftKey,
    output enableOut,
    output enableOe,
    input refClock
  );
endinterface

/* rtl/ref_clk_div.sv */
// divide-by-eight reference clock generator with period-aligned gate
`timescale 1ns/1ns
`include "tx_mode_params.svh"
module ref_clk_div (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic gate,
  output logic phaseEnd,
  output logic clkOut
);
  logic [2:0] phase;
  logic [2:0] next_phase;

  always_comb begin
    next_phase = run ? phase + `TX_DIV_ONE : `TX_DIV_ZERO;
  end

  assign phaseEnd = run && (phase == `TX_DIV_LAST);

  always_ff @(posedge mclk) begin
    if (rst) begin
      phase <= `TX_DIV_ZERO;
      clkOut <= 1'b0;
    end else begin
      phase <= next_phase;
      // output high in the first half of each eight-cycle period
      clkOut <= run && gate && (next_phase < `TX_DIV_HALF);
    end
  end
endmodule

/* rtl/tx_mode_ctrl.sv */
// transmitter end: mode decoding, crystal start-up, clock gating and lock timing
// Summary of operation
// - both keys low, enable low/open: power-down
// - open enable: power-up is key OR
// - enable low with a key: idle, all off
// - frequency key high, enable open or high: synth and oscillator on
// - clock held low until crystal amplitude reached
// - clock driver starts on a period boundary
// - synthesizer locks within 250 us of clock
// - amplitude key high with enable open or high switches amplifier on
// - controller keeps frequency key or enable active (FSK with open enable holds only the amplitude key)
// - frequency key low when powered up: load switch low impedance
// - controller holds frequency key high at start
// - keys low, enable high: powered, low impedance
// - power-down and idle: load switch high impedance
// - reference clock usable as controller clock
// - controller waits 0.6 ms before clock switch
// - controller waits further 250 us before sending
// - controller reverts to internal clock on loss
// - frequency key selects lower or higher frequency
// - controller enables, then raises amplitude key
// - shutdown drives keys low, enable low if driven, left open if open
// - reference clock is crystal divided by eight
`timescale 1ns/1ns
`include "tx_mode_params.svh"
module tx_mode_ctrl #(
  parameter int XTAL_UP_CYCLES = `TX_CYCLES_UP(`TX_XTAL_UP_NS),
  parameter int LOCK_CYCLES = `TX_CYCLES_DN(`TX_LOCK_NS)
) (
  input wire logic mclk,
  input wire logic rst,
  tx_link_if.device link,
  output tx_mode_pkg::tx_mode_e mode,
  output logic synthOn,
  output logic paOn,
  output logic loadSwitchHighZ,
  output logic freqHigh,
  output logic refClockActive,
  output logic synthLocked
);
  localparam logic [15:0] XTAL_UP = 16'(XTAL_UP_CYCLES);
  localparam logic [15:0] LOCK = 16'(LOCK_CYCLES);

  tx_mode_pkg::dev_state_s cur;
  tx_mode_pkg::dev_state_s nxt;
  tx_mode_pkg::tx_mode_e decoded;
  logic enLow;
  logic enHigh;
  logic keyAny;
  logic phaseEnd;
  logic divClk;

  function automatic tx_mode_pkg::tx_mode_e decode_mode(input logic amplitude_key_in, input logic freq_shift_key_in,
                                                        input logic low, input logic high);
    decode_mode = tx_mode_pkg::MODE_POWER_DOWN;
    if (low) begin
      if (amplitude_key_in || freq_shift_key_in) begin
        decode_mode = tx_mode_pkg::MODE_IDLE;
      end
    end else if (amplitude_key_in || freq_shift_key_in || high) begin
      // open enable powers up on either key, driven high powers up alone
      decode_mode = tx_mode_pkg::MODE_POWER_UP;
    end
  endfunction

  always_comb begin
    enLow = link.enableOe && !link.enableOut;
    enHigh = link.enableOe && link.enableOut;
    keyAny = link.amplitudeKey || link.freqShiftKey;
    decoded = decode_mode(link.amplitudeKey, link.freqShiftKey, enLow, enHigh);
    nxt = cur;
    nxt.mode = decoded;
    nxt.synthOn = (decoded == tx_mode_pkg::MODE_POWER_UP);
    nxt.paOn = (decoded == tx_mode_pkg::MODE_POWER_UP) && link.amplitudeKey;
    // only a powered oscillator can close the switch; idle and off stay high impedance
    if (decoded == tx_mode_pkg::MODE_POWER_UP) begin
      nxt.loadHighZ = link.freqShiftKey;
    end else begin
      nxt.loadHighZ = 1'b1;
    end
    nxt.freqHigh = (decoded == tx_mode_pkg::MODE_POWER_UP) && link.freqShiftKey;
    if (decoded != tx_mode_pkg::MODE_POWER_UP) begin
      // any power loss restarts the crystal from rest
      nxt.oscCnt = `TX_CNT_ZERO;
      nxt.lockCnt = `TX_CNT_ZERO;
      nxt.ampReached = 1'b0;
      nxt.clkOn = 1'b0;
      nxt.locked = 1'b0;
    end else begin
      // amplitude growth is modelled as a cycle count to the switch-on level
      if (!cur.ampReached) begin
        if (cur.oscCnt >= XTAL_UP - `TX_CNT_ONE) begin
          nxt.ampReached = 1'b1;
        end else begin
          nxt.oscCnt = cur.oscCnt + `TX_CNT_ONE;
        end
      end
      if (cur.ampReached && !cur.clkOn && phaseEnd) begin
        nxt.clkOn = 1'b1;
      end
      if (cur.clkOn && !cur.locked) begin
        if (cur.lockCnt >= LOCK - `TX_CNT_ONE) begin
          nxt.locked = 1'b1;
        end else begin
          nxt.lockCnt = cur.lockCnt + `TX_CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur <= '{mode: tx_mode_pkg::MODE_POWER_DOWN, oscCnt: `TX_CNT_ZERO, lockCnt: `TX_CNT_ZERO,
               ampReached: 1'b0, clkOn: 1'b0, locked: 1'b0, paOn: 1'b0, synthOn: 1'b0,
               loadHighZ: 1'b1, freqHigh: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  // the divider runs with the oscillator so the gate can wait for a period edge
  ref_clk_div u_div (
    .mclk(mclk),
    .rst(rst),
    .run(nxt.synthOn),
    .gate(nxt.clkOn),
    .phaseEnd(phaseEnd),
    .clkOut(divClk)
  );

  assign link.refClock = divClk;
  assign mode = cur.mode;
  assign synthOn = cur.synthOn;
  assign paOn = cur.paOn;
  assign loadSwitchHighZ = cur.loadHighZ;
  assign freqHigh = cur.freqHigh;
  assign refClockActive = cur.clkOn;
  assign synthLocked = cur.locked;
endmodule

/* rtl/tx_host_seq.sv */
// controller end: enable sequencing, clock take-over waits and keying
`timescale 1ns/1ns
`include "tx_mode_params.svh"
module tx_host_seq #(
  parameter int CLK_WAIT_CYCLES = `TX_CYCLES_UP(`TX_CLK_WAIT_NS),
  parameter int SETTLE_CYCLES = `TX_CYCLES_UP(`TX_SETTLE_NS)
) (
  input wire logic mclk,
  input wire logic rst,
  tx_link_if.controller link,
  input wire logic startReq,
  input wire logic stopReq,
  input wire logic enableHighMode,
  input wire logic fskMode,
  input wire logic dataBit,
  output logic sysClockExternal,
  output logic ready,
  output logic sending
);
  localparam logic [15:0] CLK_WAIT = 16'(CLK_WAIT_CYCLES);
  localparam logic [15:0] SETTLE = 16'(SETTLE_CYCLES);

  tx_mode_pkg::ctrl_state_s cur;
  tx_mode_pkg::ctrl_state_s nxt;
  logic refRise;

  function automatic logic count_done(input logic [15:0] cnt, input logic [15:0] limit);
    count_done = (cnt >= limit - `TX_CNT_ONE);
  endfunction

  always_comb begin
    nxt = cur;
    refRise = link.refClock && !cur.lastRef;
    nxt.lastRef = link.refClock;
    // clock monitor: a silent reference for a short window drops the selection
    if (refRise) begin
      nxt.lossCnt = `TX_LOSS_ZERO;
    end else if (cur.extSel) begin
      if (cur.lossCnt >= `TX_LOSS_CYCLES) begin
        nxt.extSel = 1'b0;
      end else begin
        nxt.lossCnt = cur.lossCnt + `TX_LOSS_ONE;
      end
    end
    unique case (cur.state)
      tx_mode_pkg::CTRL_OFF: begin
        if (startReq) begin
          nxt.freq_shift_key_in = 1'b1;
          nxt.amplitude_key_in = 1'b0;
          nxt.enOe = enableHighMode;
          nxt.enOut = enableHighMode;
          nxt.cnt = `TX_CNT_ZERO;
          nxt.state = tx_mode_pkg::CTRL_ENABLING;
        end
      end
      tx_mode_pkg::CTRL_ENABLING: begin
        if (count_done(cur.cnt, CLK_WAIT)) begin
          nxt.state = tx_mode_pkg::CTRL_SWITCH;
        end else begin
          nxt.cnt = cur.cnt + `TX_CNT_ONE;
        end
      end
      tx_mode_pkg::CTRL_SWITCH: begin
        // take over only on a live edge so the settle wait starts from a running clock
        if (refRise) begin
          nxt.extSel = 1'b1;
          nxt.lossCnt = `TX_LOSS_ZERO;
          nxt.cnt = `TX_CNT_ZERO;
          nxt.state = tx_mode_pkg::CTRL_SETTLE;
        end
      end
      tx_mode_pkg::CTRL_SETTLE: begin
        if (count_done(cur.cnt, SETTLE)) begin
          nxt.state = tx_mode_pkg::CTRL_READY;
        end else begin
          nxt.cnt = cur.cnt + `TX_CNT_ONE;
        end
      end
      tx_mode_pkg::CTRL_READY: begin
        if (startReq) begin
          nxt.state = tx_mode_pkg::CTRL_TX;
          nxt.amplitude_key_in = 1'b1;
        end
      end
      tx_mode_pkg::CTRL_TX: begin
        if (fskMode) begin
          nxt.amplitude_key_in = 1'b1;
          nxt.freq_shift_key_in = dataBit;
        end else begin
          nxt.amplitude_key_in = dataBit;
          nxt.freq_shift_key_in = 1'b1;
        end
      end
    endcase
    if (stopReq && cur.state != tx_mode_pkg::CTRL_OFF) begin
      nxt.amplitude_key_in = 1'b0;
      nxt.freq_shift_key_in = 1'b0;
      nxt.enOut = 1'b0;
      nxt.state = tx_mode_pkg::CTRL_OFF;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur <= '{state: tx_mode_pkg::CTRL_OFF, cnt: `TX_CNT_ZERO, lossCnt: `TX_LOSS_ZERO, lastRef: 1'b0,
               extSel: 1'b0, amplitude_key_in: 1'b0, freq_shift_key_in: 1'b0, enOut: 1'b0, enOe: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  assign link.amplitudeKey = cur.amplitude_key_in;
  assign link.freqShiftKey = cur.freq_shift_key_in;
  assign link.enableOut = cur.enOut;
  assign link.enableOe = cur.enOe;
  assign sysClockExternal = cur.extSel;
  assign ready = (cur.state == tx_mode_pkg::CTRL_READY);
  assign sending = (cur.state == tx_mode_pkg::CTRL_TX);
endmodule

/* verif/tx_link_properties.sv */
// concurrent checks on the link between the transmitter and its controller
`timescale 1ns/1ns
module tx_link_properties #(
  parameter int LOCK_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic amplitudeKey,
  input wire logic freqShiftKey,
  input wire logic enableOut,
  input wire logic enableOe,
  input wire logic refClock,
  input wire tx_mode_pkg::tx_mode_e mode,
  input wire logic synthOn,
  input wire logic paOn,
  input wire logic loadSwitchHighZ,
  input wire logic refClockActive,
  input wire logic synthLocked
);
  // one cycle of slack either side of the chosen lock count
  localparam int LK_LO = LOCK_CYCLES - 1;
  localparam int LK_HI = LOCK_CYCLES + 1;
  logic keyAny;
  logic enLow;
  logic enHigh;
  assign keyAny = amplitudeKey | freqShiftKey;
  assign enLow = enableOe & ~enableOut;
  assign enHigh = enableOe & enableOut;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence fullHigh;
    refClock [*4];
  endsequence
  sequence fullLow;
    !refClock [*4];
  endsequence
  chk_power_down: assert property (
    !keyAny && !enHigh |=> mode == tx_mode_pkg::MODE_POWER_DOWN) else $error("power-down missed");
  chk_open_or: assert property (
    !enableOe |=> synthOn == $past(keyAny)) else $error("open enable not key OR");
  chk_idle_off: assert property (
    enLow && keyAny |=> mode == tx_mode_pkg::MODE_IDLE && !synthOn && !paOn) else $error("idle not all off");
  chk_keys_up: assert property (
    !enLow && keyAny |=> synthOn && paOn == $past(amplitudeKey) && loadSwitchHighZ == $past(freqShiftKey))
    else $error("powered state wrong");
  chk_enable_only: assert property (
    enHigh && !keyAny |=> synthOn && !paOn && !loadSwitchHighZ) else $error("enable-only state wrong");
  chk_off_high_z: assert property (
    mode != tx_mode_pkg::MODE_POWER_UP |-> loadSwitchHighZ) else $error("load switch closed when off");
  chk_first_period: assert property (
    $rose(refClockActive) |-> fullHigh ##1 fullLow) else $error("first clock period short");
  chk_lock_time: assert property (
    $rose(refClockActive) |-> !synthLocked ##[LK_LO:LK_HI] synthLocked) else $error("lock time wrong");
  chk_key_order: assert property (
    $rose(amplitudeKey) |-> $past(freqShiftKey) && synthLocked) else $error("amplitude key raised early");
endmodule

/* verif/tx_mode_ctrl_startup_seq_tb_top.sv */
// bench joining transmitter and controller, plus a bench-driven transmitter
`timescale 1ns/1ns
`define CK(n, e, a) begin testsRun++; if ((a) !== (e)) begin \
  $display("Error %s exp %0h got %0h", n, e, a); badCount++; end end
module tx_mode_ctrl_startup_seq_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic startReq = 1'b0;
  logic stopReq = 1'b0;
  logic enableHighMode = 1'b0;
  logic fskMode = 1'b0;
  logic dataBit = 1'b0;
  int badCount = 0;
  int testsRun = 0;
  int cycles = 0;
  tx_mode_pkg::tx_mode_e mode;
  tx_mode_pkg::tx_mode_e m2;
  logic synthOn, paOn, highZ, freqHigh, clkActive, locked, pa2, hz2, extClk, ready, sending;
  tx_link_if link();
  tx_link_if link2();
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      testDone();
    end
  end
  tx_mode_ctrl #(.XTAL_UP_CYCLES(40), .LOCK_CYCLES(20)) tx_mode_ctrl_inst (.mclk(mclk), .rst(rst),
    .link(link.device), .mode(mode), .synthOn(synthOn), .paOn(paOn), .loadSwitchHighZ(highZ),
    .freqHigh(freqHigh), .refClockActive(clkActive), .synthLocked(locked));
  // second transmitter: the bench plays a controller that may break the usual order
  // only the mode table runs here, so the long default lock count is never reached
  tx_mode_ctrl #(.XTAL_UP_CYCLES(40)) tx_mode_ctrl_inst2 (.mclk(mclk), .rst(rst),
    .link(link2.device), .mode(m2), .synthOn(), .paOn(pa2), .loadSwitchHighZ(hz2), .freqHigh(),
    .refClockActive(), .synthLocked());
  tx_host_seq #(.CLK_WAIT_CYCLES(50), .SETTLE_CYCLES(30)) tx_host_seq_inst (.mclk(mclk), .rst(rst),
    .link(link.controller), .startReq(startReq), .stopReq(stopReq), .enableHighMode(enableHighMode),
    .fskMode(fskMode), .dataBit(dataBit), .sysClockExternal(extClk), .ready(ready), .sending(sending));
  // checker default lock count matches the transmitter override above
  tx_link_properties tx_link_properties_inst (.mclk(mclk), .rst(rst),
    .amplitudeKey(link.amplitudeKey), .freqShiftKey(link.freqShiftKey), .enableOut(link.enableOut),
    .enableOe(link.enableOe), .refClock(link.refClock), .mode(mode), .synthOn(synthOn), .paOn(paOn),
    .loadSwitchHighZ(highZ), .refClockActive(clkActive), .synthLocked(locked));
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_modes();
    logic a, f, on;
    int e;
    tx_mode_pkg::tx_mode_e md;
    for (int i = 0; i < 12; i++) begin
      e = i / 4;
      a = i[0];
      f = i[1];
      on = e == 1 || (e == 2 && (a | f));
      md = on ? tx_mode_pkg::MODE_POWER_UP :
        (e == 0 && (a | f)) ? tx_mode_pkg::MODE_IDLE : tx_mode_pkg::MODE_POWER_DOWN;
      link2.amplitudeKey = a;
      link2.freqShiftKey = f;
      link2.enableOe = e != 2;
      link2.enableOut = e == 1;
      @(negedge mclk);
      `CK("modes", {md, on & a, ~(on & ~f)}, {m2, pa2, hz2})
    end
    $display("mode table done");
  endtask
  task automatic t_run(input logic hi, input logic fm);
    int n;
    n = 0;
    enableHighMode = hi;
    fskMode = fm;
    startReq = 1'b1;
    @(negedge mclk);
    startReq = 1'b0;
    `CK("start", {1'b1, 1'b0, hi, hi}, {link.freqShiftKey, link.amplitudeKey, link.enableOe, link.enableOut})
    // a stray start while enabling must be ignored
    while (extClk !== 1'b1 && n < 300) begin
      @(negedge mclk);
      startReq = (n == 5);
      n++;
    end
    `CK("clkWait", 1'b1, n >= 50)
    `CK("clkOn", 1'b1, clkActive)
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    `CK("settle", 1'b1, n >= 30)
    `CK("lock", 1'b1, locked)
    startReq = 1'b1;
    @(negedge mclk);
    startReq = 1'b0;
    `CK("sending", 2'h2, {sending, ready})
    for (int b = 0; b < 2; b++) begin
      dataBit = b[0];
      repeat (2) @(negedge mclk);
      `CK("tx", {fm | b[0], ~fm | b[0], fm | b[0], ~fm | b[0]}, {link.amplitudeKey, link.freqShiftKey, paOn, freqHigh})
    end
    stopReq = 1'b1;
    @(negedge mclk);
    stopReq = 1'b0;
    `CK("stop", {3'h0, hi}, {link.amplitudeKey, link.freqShiftKey, link.enableOut, link.enableOe})
    @(negedge mclk);
    `CK("down", tx_mode_pkg::MODE_POWER_DOWN, mode)
    n = 0;
    while (extClk !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    `CK("clkBack", 2'h0, {extClk, link.refClock})
    $display("run enable=%0d fsk=%0d done", hi, fm);
  endtask
  initial begin
    link2.amplitudeKey = 1'b0;
    link2.freqShiftKey = 1'b0;
    link2.enableOe = 1'b0;
    link2.enableOut = 1'b0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    t_modes();
    for (int m = 0; m < 4; m++) begin
      t_run(m[1], m[0]);
    end
    testDone();
  end
endmodule
